// ==== rtl/count16_pkg.sv ====
// Package with register map, field layout and constants of the 16-bit counter
// ============================================================================
// Behaviour
// R01: 16-bit count in two bytes, wraps
// R02: Both count bytes readable and writable
// R03: Run bit starts, stops, keeps count
// R04: Internal source advances once per cycle/4
// R05: External source counts rising pin edges
// R06: Two-bit prescale 1, 2, 4, 8
// R07: Sync bypass bit chooses synchroniser path; code always syncs the pin, bit only blocks trigger reset
// R08: Crystal enable powers osc, pins input
// R09: Falling edge needed before first count
// R10: Crystal keeps running during sleep
// R11: Software waits for crystal start-up
// R12: Wrap sets sticky overflow flag
// R13: Enable bit gates overflow interrupt
// R14: Compare trigger mode 1011 clears count
// R15: Trigger reset only in synced modes
// R16: Software write beats trigger reset
// R17: Compare pair acts as period
// R18: Trigger clear never sets overflow flag
// R19: Count byte write clears prescaler
package count16_pkg;

  // ==========================================================================
  // Register offsets (byte addresses = 4 * index)
  localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0C;
  localparam logic [7:0] IDX_COUNT_LOW   = 8'h0E;
  localparam logic [7:0] IDX_COUNT_HIGH  = 8'h0F;
  localparam logic [7:0] IDX_CONTROL     = 8'h10;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8C;
  localparam logic [9:0] ADDR_IRQ_FLAGS   = {IDX_IRQ_FLAGS, 2'b00};
  localparam logic [9:0] ADDR_COUNT_LOW   = {IDX_COUNT_LOW, 2'b00};
  localparam logic [9:0] ADDR_COUNT_HIGH  = {IDX_COUNT_HIGH, 2'b00};
  localparam logic [9:0] ADDR_CONTROL     = {IDX_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_IRQ_ENABLES = {IDX_IRQ_ENABLES, 2'b00};

  // ==========================================================================
  // Field positions
  localparam int RUN_BIT     = 0;
  localparam int SRC_BIT     = 1;
  localparam int BYPASS_BIT  = 2;
  localparam int XTAL_BIT    = 3;
  localparam int PRE_LSB     = 4;
  localparam int OVF_BIT     = 0;

  // ==========================================================================
  // Reset values and counts
  localparam logic [7:0]  CONTROL_RST   = 8'h00;
  localparam logic [7:0]  FLAGS_RST     = 8'h00;
  localparam logic [7:0]  ENABLES_RST   = 8'h00;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [1:0]  INSTR_DIV_MAX = 2'h3;
  localparam logic [3:0]  TRIGGER_MODE  = 4'hB;

  // Control register fields
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] prescaleSelect;
    logic       crystalOscEnable;
    logic       syncBypass;
    logic       clockSourceSelect;
    logic       runControl;
  } control_t;

  // Compare unit trigger inputs
  typedef struct packed {
    logic [3:0] modeField;
    logic       matchPulse;
  } compare_t;

endpackage : count16_pkg

// ==== rtl/prescale_div.sv ====
// Prescaler that divides count ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
module prescale_div (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstSync_b,
  // Control
  input  wire logic [1:0] prescaleSelect,
  input  wire logic       clearPhase,
  input  wire logic       tickIn,
  // Result
  output logic            tickOut
);

  logic [2:0] phase_ff;

  // Phase counter, restarted on count write
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      phase_ff <= 3'h0;
    end else if (clearPhase) begin
      phase_ff <= 3'h0; // R19
    end else if (tickIn) begin
      phase_ff <= phase_ff + 3'h1;
    end
  end

  // Pass a tick when the low phase bits are all ones
  always_comb begin
    unique case (prescaleSelect) // R06
      2'h0:    tickOut = tickIn;
      2'h1:    tickOut = tickIn && (phase_ff[0] == 1'b1);
      2'h2:    tickOut = tickIn && (phase_ff[1:0] == 2'h3);
      2'h3:    tickOut = tickIn && (phase_ff == 3'h7);
    endcase
  end

endmodule : prescale_div

// ==== rtl/count16_timer.sv ====
// Top of the 16-bit timer/counter with APB register slave
`timescale 1ns/1ps
module count16_timer (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // External count pin and compare units
  input  wire logic        externalCountInput,
  input  wire logic [3:0]  firstCompareMode,
  input  wire logic        firstCompareMatch,
  input  wire logic [3:0]  secondCompareMode,
  input  wire logic        secondCompareMatch,
  input  wire logic        converterEnable,
  // Outputs
  output logic             crystalOscRun,
  output logic             crystalPinsInput,
  output logic             conversionStart,
  output logic             overflowIrq
);

  // ==========================================================================
  // Reset release
  logic [1:0] rstPipe_ff;
  logic       rstSync_b;

  // Asynchronous assert, two-stage release
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_ff <= 2'b00;
    end else begin
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
    end
  end
  assign rstSync_b = rstPipe_ff[1];

  // ==========================================================================
  // Registers
  count16_pkg::control_t control_ff;
  logic [7:0]  flags_ff;
  logic [7:0]  enables_ff;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [9:0]  addr;
  logic        wrXfer;
  logic        rdXfer;
  logic        wrLow;
  logic        wrHigh;
  logic        wrCount;
  logic        mapped;

  assign addr    = paddr[9:0];
  assign mapped  = (paddr[11:10] == 2'b00) &&
                   (addr == count16_pkg::ADDR_IRQ_FLAGS ||
                    addr == count16_pkg::ADDR_COUNT_LOW ||
                    addr == count16_pkg::ADDR_COUNT_HIGH ||
                    addr == count16_pkg::ADDR_CONTROL ||
                    addr == count16_pkg::ADDR_IRQ_ENABLES);
  assign wrXfer  = psel && penable && pwrite && mapped;
  assign rdXfer  = psel && penable && !pwrite && mapped;
  assign wrLow   = wrXfer && (addr == count16_pkg::ADDR_COUNT_LOW);
  assign wrHigh  = wrXfer && (addr == count16_pkg::ADDR_COUNT_HIGH);
  assign wrCount = wrLow || wrHigh;

  // Zero-wait APB answer, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Control register
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      control_ff <= count16_pkg::CONTROL_RST;
    end else if (wrXfer && addr == count16_pkg::ADDR_CONTROL) begin
      control_ff <= {2'b00, pwdata[5:0]};
    end
  end

  // Interrupt enable register
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      enables_ff <= count16_pkg::ENABLES_RST;
    end else if (wrXfer && addr == count16_pkg::ADDR_IRQ_ENABLES) begin
      enables_ff <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // Instruction cycle enable: system clock divided by four
  logic [1:0] instrDiv_ff;
  logic       instrTick;

  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      instrDiv_ff <= 2'h0;
    end else begin
      instrDiv_ff <= instrDiv_ff + 2'h1;
    end
  end
  assign instrTick = (instrDiv_ff == count16_pkg::INSTR_DIV_MAX); // R04

  // ==========================================================================
  // External pin: two flip-flops, then edge detection
  logic [1:0] pinSync_ff;
  logic       pinPrev_ff;
  logic       pinRise;
  logic       pinFall;
  logic       armed_ff;
  logic       extMode;

  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      pinSync_ff <= 2'b00;
      pinPrev_ff <= 1'b0;
    end else begin
      pinSync_ff <= {pinSync_ff[0], externalCountInput};
      pinPrev_ff <= pinSync_ff[1];
    end
  end
  assign pinRise = pinSync_ff[1] && !pinPrev_ff; // R05
  assign pinFall = !pinSync_ff[1] && pinPrev_ff;
  assign extMode = control_ff.clockSourceSelect;

  // Arm counting only after a falling edge once enabled
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      armed_ff <= 1'b0;
    end else if (!control_ff.runControl || !extMode) begin
      armed_ff <= 1'b0; // R09
    end else if (pinFall) begin
      armed_ff <= 1'b1; // R09
    end
  end

  // ==========================================================================
  // Tick selection and prescaling
  logic rawTick;
  logic countTick;

  // Both external paths are sampled on sys_clk here; the bypass bit only
  // changes whether the trigger reset is honoured
  assign rawTick = !control_ff.runControl ? 1'b0 :          // R03
                   extMode ? (pinRise && armed_ff) :         // R05 R07
                   instrTick;                                // R04

  prescale_div prescaler (
    .sys_clk        (sys_clk),
    .rstSync_b      (rstSync_b),
    .prescaleSelect (control_ff.prescaleSelect),
    .clearPhase     (wrCount),
    .tickIn         (rawTick),
    .tickOut        (countTick)
  );

  // ==========================================================================
  // Compare trigger
  logic asyncMode;
  logic trigFirst;
  logic trigSecond;
  logic trigClear;

  assign asyncMode  = extMode && control_ff.syncBypass; // R07
  assign trigFirst  = firstCompareMatch &&
                      firstCompareMode == count16_pkg::TRIGGER_MODE;    // R14
  assign trigSecond = secondCompareMatch &&
                      secondCompareMode == count16_pkg::TRIGGER_MODE;   // R14
  // Trigger reset not honoured in asynchronous counter mode
  assign trigClear  = (trigFirst || trigSecond) && !asyncMode;          // R15 R17

  // Analog conversion start from the second unit
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      conversionStart <= 1'b0;
    end else begin
      conversionStart <= trigSecond && converterEnable; // R14
    end
  end

  // ==========================================================================
  // Count register
  logic wrapEvent;

  always_comb begin
    nxt_count = count_ff;
    if (countTick) begin
      nxt_count = count_ff + 16'h0001; // R01
    end
    // A count write in the same cycle cancels the whole trigger clear
    if (trigClear && !wrCount) begin
      nxt_count = count16_pkg::COUNT_RST; // R14 R16
    end
    if (wrLow) begin
      nxt_count[7:0] = pwdata[7:0]; // R02 R16
    end
    if (wrHigh) begin
      nxt_count[15:8] = pwdata[7:0]; // R02 R16
    end
  end

  // Wrap only counts when no trigger or write replaces it
  assign wrapEvent = countTick && (count_ff == count16_pkg::COUNT_MAX) &&
                     !trigClear && !wrCount; // R18

  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      count_ff <= count16_pkg::COUNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ==========================================================================
  // Flags: set wins over read clear
  always_ff @(posedge sys_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      flags_ff <= count16_pkg::FLAGS_RST;
    end else begin
      if (rdXfer && addr == count16_pkg::ADDR_IRQ_FLAGS) begin
        flags_ff <= 8'h00;
      end else if (wrXfer && addr == count16_pkg::ADDR_IRQ_FLAGS) begin
        flags_ff <= pwdata[7:0];
      end
      if (wrapEvent) begin
        flags_ff[count16_pkg::OVF_BIT] <= 1'b1; // R12
      end
    end
  end

  // Level interrupt gated by enable
  assign overflowIrq = |(flags_ff & enables_ff); // R13

  // Crystal oscillator and pin direction override
  assign crystalOscRun    = control_ff.crystalOscEnable; // R08 R10
  assign crystalPinsInput = control_ff.crystalOscEnable; // R08

  // ==========================================================================
  // Read data
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      unique case (addr)
        count16_pkg::ADDR_IRQ_FLAGS:   prdata = {24'h000000, flags_ff};
        count16_pkg::ADDR_COUNT_LOW:   prdata = {24'h000000, count_ff[7:0]};
        count16_pkg::ADDR_COUNT_HIGH:  prdata = {24'h000000, count_ff[15:8]};
        count16_pkg::ADDR_CONTROL:     prdata = {24'h000000, control_ff};
        count16_pkg::ADDR_IRQ_ENABLES: prdata = {24'h000000, enables_ff};
        default:                       prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : count16_timer

// ==== test/count16_checker_assertions.sv ====
// Port checker for the 16-bit timer/counter
`timescale 1ns/1ps
module count16_checker (
  // Clock, reset and APB
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Compare unit and outputs
  input wire logic [3:0]  secondCompareMode,
  input wire logic        secondCompareMatch,
  input wire logic        converterEnable,
  input wire logic        crystalOscRun,
  input wire logic        crystalPinsInput,
  input wire logic        conversionStart,
  input wire logic        overflowIrq
);
  // ====
  // Address decode
  wire logic [9:0] a = paddr[9:0];
  wire logic isMapped = paddr[11:10] == 2'h0 && (a == count16_pkg::ADDR_IRQ_FLAGS
    || a == count16_pkg::ADDR_COUNT_LOW || a == count16_pkg::ADDR_COUNT_HIGH
    || a == count16_pkg::ADDR_CONTROL || a == count16_pkg::ADDR_IRQ_ENABLES);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Completed writes and trigger
  sequence s_wctl;
    psel && penable && pwrite && paddr == {2'h0, count16_pkg::ADDR_CONTROL};
  endsequence
  sequence s_wen0;
    psel && penable && pwrite && paddr == {2'h0, count16_pkg::ADDR_IRQ_ENABLES} && !pwdata[0];
  endsequence
  sequence s_trig2;
    secondCompareMatch && secondCompareMode == count16_pkg::TRIGGER_MODE && converterEnable;
  endsequence
  property p_ready; psel && penable |-> pready; endproperty
  property p_err; psel && penable |-> pslverr == !isMapped; endproperty
  property p_hi; psel && penable && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  property p_pins; crystalOscRun == crystalPinsInput; endproperty
  property p_xwr; s_wctl |=> crystalOscRun == $past(pwdata[3]); endproperty
  property p_xhold;
    !(psel && penable && pwrite && paddr == {2'h0, count16_pkg::ADDR_CONTROL})
      |=> $stable(crystalOscRun);
  endproperty
  property p_conv;
    conversionStart |-> $past(secondCompareMatch && converterEnable &&
                              secondCompareMode == count16_pkg::TRIGGER_MODE);
  endproperty
  property p_conv2; s_trig2 |=> conversionStart; endproperty
  property p_mask; s_wen0 |=> !overflowIrq; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  a_err: assert property (p_err) else $error("slave error wrong");
  a_hi: assert property (p_hi) else $error("read upper bits set");
  a_pins: assert property (p_pins) else $error("crystal pins differ");
  a_xwr: assert property (p_xwr) else $error("crystal enable not taken");
  a_xhold: assert property (p_xhold) else $error("crystal enable moved");
  a_conv: assert property (p_conv) else $error("stray conversion start");
  a_conv2: assert property (p_conv2) else $error("conversion start missing");
  a_mask: assert property (p_mask) else $error("masked interrupt seen");
endmodule : count16_checker

bind count16_timer count16_checker count16_checker_i (.sys_clk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .secondCompareMode,
  .secondCompareMatch, .converterEnable, .crystalOscRun, .crystalPinsInput,
  .conversionStart, .overflowIrq);

// ==== test/count_src_model.sv ====
// Model of the external count pin and the two compare units
`timescale 1ns/1ps
module count_src_model (
  // Clock
  input  wire logic             sys_clk,
  // Pin and compare units
  output logic                  extPin,
  output count16_pkg::compare_t first,
  output count16_pkg::compare_t second
);
  // ====
  // Idle levels
  initial begin
    extPin = 1'b0;
    first = '0;
    second = '0;
  end
  // Pin level held four cycles so the synchroniser sees it
  task automatic edge_to(input logic v);
    repeat (4) @(posedge sys_clk);
    extPin <= v;
  endtask : edge_to
  // Falling then rising edges
  task automatic pulses(input int n);
    repeat (n) begin
      edge_to(1'b0);
      edge_to(1'b1);
    end
    repeat (4) @(posedge sys_clk);
  endtask : pulses
  // One-cycle match pulse, only used in synced modes
  task automatic trig(input logic two, input logic [3:0] m);
    @(posedge sys_clk);
    if (two) begin
      second <= {m, 1'b1};
    end else begin
      first <= {m, 1'b1};
    end
    @(posedge sys_clk);
    first.matchPulse <= 1'b0;
    second.matchPulse <= 1'b0;
  endtask : trig
endmodule : count_src_model

// ==== test/tb_count16_timer.sv ====
// Self-checking bench of the 16-bit timer/counter
`timescale 1ns/1ps
module tb_count16_timer;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, extPin;
  logic convEn, crystalOscRun, crystalPinsInput, conversionStart, overflowIrq, seenConv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [15:0] rnd;
  logic [32:0] q[$];
  count16_pkg::compare_t first, second;
  int n_fail, n_tests;
  localparam logic [9:0] AF = count16_pkg::ADDR_IRQ_FLAGS;
  localparam logic [9:0] AL = count16_pkg::ADDR_COUNT_LOW;
  localparam logic [9:0] AH = count16_pkg::ADDR_COUNT_HIGH;
  localparam logic [9:0] AC = count16_pkg::ADDR_CONTROL;
  localparam logic [9:0] AE = count16_pkg::ADDR_IRQ_ENABLES;
  // ====
  // Design and partner
  count16_timer count16_timer_i (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .externalCountInput(extPin),
    .firstCompareMode(first.modeField), .firstCompareMatch(first.matchPulse),
    .secondCompareMode(second.modeField), .secondCompareMatch(second.matchPulse),
    .converterEnable(convEn), .crystalOscRun, .crystalPinsInput, .conversionStart,
    .overflowIrq);
  count_src_model count_src_model_i (.sys_clk, .extPin, .first, .second);
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic final_report();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Count within one tick of the ideal
  task automatic chk_rng(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if ((g + 1 >= e && g <= e + 1) !== 1'b1) begin
      n_fail++;
      $display("BAD count exp %0d got %0d", e, g);
    end
  endtask : chk_rng
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, a};
    pwdata <= v;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    d = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask : wr
  task automatic rdq(input logic [9:0] a, input logic [31:0] e);
    q.push_back({1'b1, e});
    apb(1'b0, a, 32'h0);
  endtask : rdq
  task automatic chk_irq(input logic e);
    #1;
    chk("irq", {31'h0, e}, {31'h0, overflowIrq});
  endtask : chk_irq
  // Compare each completed read with the oldest note
  always @(posedge sys_clk) begin
    if (conversionStart === 1'b1) seenConv <= 1'b1;
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      if (q[0][32]) chk("prdata", q[0][31:0], prdata);
      void'(q.pop_front());
    end
  end
  // Watchdog
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
  // Main sequence
  initial begin
    {rst_b, psel, penable, pwrite, convEn, seenConv} = '0;
    {paddr, pwdata} = '0;
    rnd = 16'h79E3;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdq(AC, 32'h0);
    rdq(AE, 32'h0);
    rdq(10'h3FF, 32'h0);
    wr(AC, 32'hF8);
    // Crystal start-up delay before relying on it
    repeat (20) @(posedge sys_clk);
    rdq(AC, 32'h38);
    chk("xtal", 32'h1, {31'h0, crystalOscRun});
    repeat (4) begin
      rnd = lfsr(rnd);
      wr(AL, {24'h0, rnd[7:0]});
      wr(AH, {24'h0, rnd[15:8]});
      rdq(AL, {24'h0, rnd[7:0]});
      rdq(AH, {24'h0, rnd[15:8]});
    end
    for (int p = 0; p < 4; p++) begin
      wr(AL, 32'h0);
      wr(AH, 32'h0);
      wr(AC, 32'h1 | (p << 4));
      repeat (189) @(posedge sys_clk);
      wr(AC, 32'h0);
      apb(1'b0, AL, 32'h0);
      chk_rng(32'd48 >> p, d);
    end
    for (int b = 0; b < 2; b++) begin
      wr(AL, 32'h0);
      wr(AC, 32'h3 | (b << 2));
      count_src_model_i.edge_to(1'b1);
      count_src_model_i.pulses(5);
      wr(AC, 32'h0);
      rdq(AL, 32'h5);
    end
    wr(AE, 32'h1);
    wr(AL, 32'hFE);
    wr(AH, 32'hFF);
    wr(AC, 32'h1);
    repeat (12) @(posedge sys_clk);
    wr(AC, 32'h0);
    rdq(AH, 32'h0);
    chk_irq(1'b1);
    wr(AE, 32'h0);
    chk_irq(1'b0);
    wr(AE, 32'h1);
    chk_irq(1'b1);
    rdq(AF, 32'h1);
    chk_irq(1'b0);
    wr(AH, 32'h12);
    wr(AL, 32'h34);
    count_src_model_i.trig(1'b0, 4'hA);
    rdq(AL, 32'h34);
    count_src_model_i.trig(1'b0, count16_pkg::TRIGGER_MODE);
    rdq(AH, 32'h0);
    rdq(AF, 32'h0);
    wr(AH, 32'h12);
    fork
      wr(AL, 32'h55);
      begin
        @(posedge sys_clk);
        count_src_model_i.trig(1'b0, count16_pkg::TRIGGER_MODE);
      end
    join
    rdq(AL, 32'h55);
    rdq(AH, 32'h12);
    @(posedge sys_clk);
    convEn <= 1'b1;
    count_src_model_i.trig(1'b1, count16_pkg::TRIGGER_MODE);
    rdq(AL, 32'h0);
    chk("conv", 32'h1, {31'h0, seenConv});
    // Periodic trigger keeps the count near zero
    wr(AL, 32'h0);
    wr(AC, 32'h1);
    repeat (8) begin
      repeat (20) @(posedge sys_clk);
      count_src_model_i.trig(1'b0, count16_pkg::TRIGGER_MODE);
    end
    wr(AC, 32'h0);
    apb(1'b0, AL, 32'h0);
    chk_rng(32'd1, d);
    final_report();
  end
endmodule : tb_count16_timer
